/* logic/vsm_pkg.sv */
// Package: register map, field layout and carrier types of the sync measure
package vsm_pkg;

  // Widths of the measured quantities, port selector, event set and bus address
  localparam int HALF_W = 14;
  localparam int LINE_W = 13;
  localparam int PSEL_W = 3;
  localparam int EVT_W  = 3;
  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_INTERLACE  = 8'h0B;
  localparam logic [7:0] IDX_F1_PULSE   = 8'h30;
  localparam logic [7:0] IDX_F1_PORCH   = 8'h34;
  localparam logic [7:0] IDX_ALT_EN     = 8'h4C;
  localparam logic [7:0] IDX_CTRL       = 8'h50;
  localparam logic [7:0] IDX_REQ        = 8'h51;
  localparam logic [7:0] IDX_STATUS     = 8'h52;
  localparam logic [7:0] IDX_IRQ_STAT   = 8'h53;
  localparam logic [7:0] IDX_IRQ_CLR    = 8'h54;
  localparam logic [7:0] IDX_IRQ_EN     = 8'h55;
  localparam logic [7:0] IDX_SIDE_ACT   = 8'hE6;
  localparam logic [7:0] IDX_SIDE_TOT   = 8'hE8;
  localparam logic [7:0] IDX_SIDE_IL    = 8'hEA;

  // Field positions
  localparam int INTERLACE_BIT = 5;
  localparam int ALT_EN_BIT    = 2;
  localparam int SIDE_IL_BIT   = 0;
  localparam int MAIN_PORT_LSB = 0;
  localparam int SIDE_PORT_LSB = 4;
  localparam int REQ_BIT       = 0;
  localparam int ST_FILT_BIT   = 0;
  localparam int ST_RAW_BIT    = 1;
  localparam int ST_SIDE_BIT   = 2;
  localparam int ST_PEND_BIT   = 3;
  localparam int EVT_LOCK_BIT  = 0;
  localparam int EVT_LOST_BIT  = 1;
  localparam int EVT_SIDE_BIT  = 2;

  // Reset values
  localparam logic [PSEL_W-1:0] PORT_RST   = 3'h0;
  localparam logic              ALT_RST    = 1'b0;
  localparam logic [EVT_W-1:0]  IRQ_EN_RST = 3'h0;

  // Field measurement sequence
  typedef enum logic [1:0] {
    VSM_IDLE, VSM_PULSE, VSM_PORCH, VSM_ACTIVE
  } vsm_fstate_type;

  // One decoded sync stream
  typedef struct packed {
    logic vs;
    logic hs;
    logic de;
  } vsm_sync_type;

  // Results of one completed field
  typedef struct packed {
    logic [HALF_W-1:0] tot_half;
    logic [HALF_W-1:0] pw;
    logic [HALF_W-1:0] bp;
    logic [LINE_W-1:0] act;
    logic              mid;
  } vsm_field_type;

endpackage

/* logic/vsm_vertical_measure.sv */
// Vertical sync measurement of a main and a background port, APB registers
//
// Functional notes
// - Field 1 sync pulse width readable, 14 bits, in half lines.
// - Field 1 back porch readable, 14 bits, half lines, pulse end to active.
// - Main readbacks meaningful only while the vertical filter reports lock.
// - Field 1 results meaningful only when the interlace flag reads one.
// - Interlace flag from vertical filter: 0 progressive, 1 interlaced.
// - Background port chosen by 3-bit selector; valid while settled flag high.
// - Background total field height, 13 bits, lines, refreshed on request.
// - Background active field height, 13 bits, refreshed on request.
// - Background interlace flag updated on request, valid while settled.
// - Filter locks when sync arrives at same count two consecutive frames.
// - Filter unlocks when sync position differs two consecutive fields.
// - One enable bit selects the alternative vertical extraction.
// - Main measurements use the port chosen by the 3-bit main selector.
// - Raw lock flag reads 1 when filter locked, else 0.
`timescale 1ns/1ns
module vsm_vertical_measure
  import vsm_pkg::*;
#(
  parameter int NUM_PORTS = 2,   // Number of sync input ports
  parameter int PIX_W     = 16   // Width of the pixel counter
) (
  input  wire logic                           pclk,      // Bus clock
  input  wire logic                           presetn,   // Async reset
  input  wire logic                           psel,      // APB select
  input  wire logic                           penable,   // APB enable
  input  wire logic                           pwrite,    // APB direction
  input  wire logic [vsm_pkg::ADDR_W-1:0]     paddr,     // APB byte address
  input  wire logic [31:0]                    pwdata,    // APB write data
  input  wire logic [3:0]                     pstrb,     // APB byte strobes
  output logic [31:0]                         prdata,    // APB read data
  output logic                                pready,    // APB ready
  output logic                                pslverr,   // APB error
  input  wire vsm_pkg::vsm_sync_type [NUM_PORTS-1:0] port_sync, // Pins
  output logic                                irq        // Level interrupt
);
  import vsm_pkg::*;

  // Parameter check
  if (NUM_PORTS < 1 || NUM_PORTS > 8 || PIX_W < 4) begin : g_chk
    $error("vsm_vertical_measure: unsupported parameter values");
  end

  localparam logic [ADDR_W-1:0] A_INTERLACE = {2'b00, IDX_INTERLACE, 2'b00};
  localparam logic [ADDR_W-1:0] A_F1_PULSE  = {2'b00, IDX_F1_PULSE, 2'b00};
  localparam logic [ADDR_W-1:0] A_F1_PORCH  = {2'b00, IDX_F1_PORCH, 2'b00};
  localparam logic [ADDR_W-1:0] A_ALT_EN    = {2'b00, IDX_ALT_EN, 2'b00};
  localparam logic [ADDR_W-1:0] A_CTRL      = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_REQ       = {2'b00, IDX_REQ, 2'b00};
  localparam logic [ADDR_W-1:0] A_STATUS    = {2'b00, IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] A_IRQ_STAT  = {2'b00, IDX_IRQ_STAT, 2'b00};
  localparam logic [ADDR_W-1:0] A_IRQ_CLR   = {2'b00, IDX_IRQ_CLR, 2'b00};
  localparam logic [ADDR_W-1:0] A_IRQ_EN    = {2'b00, IDX_IRQ_EN, 2'b00};
  localparam logic [ADDR_W-1:0] A_SIDE_ACT  = {2'b00, IDX_SIDE_ACT, 2'b00};
  localparam logic [ADDR_W-1:0] A_SIDE_TOT  = {2'b00, IDX_SIDE_TOT, 2'b00};
  localparam logic [ADDR_W-1:0] A_SIDE_IL   = {2'b00, IDX_SIDE_IL, 2'b00};

  // Two-flop synchronisers on the sync pins
  vsm_sync_type [NUM_PORTS-1:0] meta_q;
  vsm_sync_type [NUM_PORTS-1:0] sync_q;

  // Software controls
  logic [PSEL_W-1:0] main_port_q;
  logic [PSEL_W-1:0] side_port_choice_q;
  logic              alt_vertical_extract_enable_q;
  logic              side_refresh_request_q;
  logic [EVT_W-1:0]  irq_en_q;
  logic [EVT_W-1:0]  irq_st_q;

  // Per-engine results; engine 0 is the main port, 1 the background
  logic [PSEL_W-1:0] eng_sel [2];
  logic              eng_alt [2];
  vsm_field_type     res_q   [2];
  logic              done_q  [2];
  logic              lock_q  [2];
  logic              ilace_q [2];
  logic              mprev_q [2];

  // Main port readbacks
  logic [HALF_W-1:0] field1_sync_pulse_width_q;
  logic [HALF_W-1:0] field1_sync_back_porch_q;
  logic              filt_lock_q;
  logic              lock_prev_q;

  // Background readbacks
  logic [LINE_W-1:0] side_total_field_height_q;
  logic [LINE_W-1:0] side_active_field_height_q;
  logic              side_interlace_flag_q;

  // Bus
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              irq_q;
  logic [31:0]       rd_data;
  logic              rd_hit;
  logic              wr_en;
  logic [EVT_W-1:0]  evt;

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  // Pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= port_sync;
      sync_q <= meta_q;
    end
  end

  assign eng_sel[0] = main_port_q;
  assign eng_sel[1] = side_port_choice_q;
  assign eng_alt[0] = alt_vertical_extract_enable_q;
  assign eng_alt[1] = 1'b1;                          // Background always alt

  // Identical measurement engines for the main and the background port
  for (genvar e = 0; e < 2; e++) begin : g_eng
    vsm_sync_type      cur;
    vsm_sync_type      prv_q;
    logic [PIX_W-1:0]  pix_q;
    logic [PIX_W-1:0]  llen_q;
    logic              hp_q;
    logic [HALF_W-1:0] tot_q;
    logic [HALF_W-1:0] pw_q;
    logic [HALF_W-1:0] bp_q;
    logic [LINE_W-1:0] act_q;
    logic              mid_q;
    vsm_fstate_type    st_q;
    logic [PSEL_W-1:0] sel_prev_q;
    logic [HALF_W-1:0] h1_q;
    logic [HALF_W-1:0] h2_q;
    logic              miss_q;
    logic              hs_rise;
    logic              vs_rise;
    logic              vs_fall;
    logic              de_rise;
    logic              half_tick;
    logic              port_chg;

    // Unused selector codes see a quiet port
    always_comb begin
      cur = '0;
      if (32'(eng_sel[e]) < NUM_PORTS) begin
        cur = sync_q[eng_sel[e]];
      end
    end

    assign hs_rise   = cur.hs & ~prv_q.hs;
    assign vs_rise   = cur.vs & ~prv_q.vs;
    assign vs_fall   = ~cur.vs & prv_q.vs;
    assign de_rise   = cur.de & ~prv_q.de;
    assign port_chg  = eng_sel[e] != sel_prev_q;
    // Ticks at line start and at pixel llen/2 give half-line units
    assign half_tick = hs_rise | (!hp_q && llen_q != '0
                       && pix_q + 1'b1 == (llen_q >> 1)); // pix_q lags a pixel

    // Line length tracking, taken from the previous line
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prv_q      <= '0;
        pix_q      <= '0;
        llen_q     <= '0;
        hp_q       <= 1'b0;
        sel_prev_q <= '0;
      end else begin
        prv_q      <= cur;
        sel_prev_q <= eng_sel[e];
        if (hs_rise) begin
          pix_q  <= '0;
          llen_q <= pix_q + 1'b1;
          hp_q   <= 1'b0;
        end else begin
          if (pix_q != '1) begin
            pix_q <= pix_q + 1'b1;
          end
          if (half_tick) begin
            hp_q <= 1'b1;
          end
        end
      end
    end

    // Field sequence: pulse, back porch, active, closed by next sync edge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q     <= VSM_IDLE;
        tot_q    <= '0;
        pw_q     <= '0;
        bp_q     <= '0;
        act_q    <= '0;
        mid_q    <= 1'b0;
        done_q[e] <= 1'b0;
        res_q[e]  <= '0;
      end else begin
        done_q[e] <= 1'b0;
        if (port_chg) begin
          st_q <= VSM_IDLE;
        end else if (vs_rise) begin
          if (st_q != VSM_IDLE) begin
            done_q[e] <= 1'b1;
            res_q[e]  <= '{tot_half: tot_q, pw: pw_q, bp: bp_q,
                           act: act_q, mid: mid_q};
          end
          tot_q <= '0;
          pw_q  <= '0;
          bp_q  <= '0;
          act_q <= '0;
          mid_q <= hp_q;   // Sync arriving mid-line marks field 1
          st_q  <= VSM_PULSE;
        end else begin
          if (half_tick && st_q != VSM_IDLE) begin
            tot_q <= tot_q + 1'b1;
          end
          case (st_q)
            VSM_PULSE: begin
              if (half_tick) begin
                pw_q <= pw_q + 1'b1;
              end
              if (vs_fall) begin
                st_q <= VSM_PORCH;
              end
            end
            VSM_PORCH: begin
              if (de_rise) begin
                act_q <= 13'h0001;
                st_q  <= VSM_ACTIVE;
              end else if (half_tick) begin
                bp_q <= bp_q + 1'b1;
              end
            end
            VSM_ACTIVE: begin
              if (de_rise) begin
                act_q <= act_q + 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end

    // Lock filter compares each field with the one two fields back (one frame back when interlaced)
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lock_q[e]  <= 1'b0;
        miss_q     <= 1'b0;
        h1_q       <= '0;
        h2_q       <= '0;
        ilace_q[e] <= 1'b0;
        mprev_q[e] <= 1'b0;
      end else if (port_chg) begin
        lock_q[e] <= 1'b0;
        miss_q    <= 1'b0;
        h1_q      <= '0;
        h2_q      <= '0;
      end else if (done_q[e]) begin
        h2_q       <= h1_q;
        h1_q       <= res_q[e].tot_half;
        mprev_q[e] <= res_q[e].mid;
        if (res_q[e].tot_half == h2_q && h2_q != '0) begin
          lock_q[e] <= 1'b1;
          miss_q    <= 1'b0;
        end else begin
          miss_q <= 1'b1;
          if (miss_q) begin
            lock_q[e] <= 1'b0;
          end
        end
        // Alt method: phase alternation; default: odd half-line count
        if (eng_alt[e]) begin
          ilace_q[e] <= res_q[e].mid ^ mprev_q[e];
        end else begin
          ilace_q[e] <= res_q[e].tot_half[0];
        end
      end
    end
  end

  // Field 1 readbacks, captured only from a locked field 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field1_sync_pulse_width_q <= '0;
      field1_sync_back_porch_q  <= '0;
    end else if (done_q[0] && res_q[0].mid && lock_q[0]) begin
      field1_sync_pulse_width_q <= res_q[0].pw;
      field1_sync_back_porch_q  <= res_q[0].bp;
    end
  end

  // Filter reports lock once a field completes under raw lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_lock_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_q[0];
      if (!lock_q[0]) begin
        filt_lock_q <= 1'b0;
      end else if (done_q[0]) begin
        filt_lock_q <= 1'b1;
      end
    end
  end

  // Background capture waits for a fresh field so the set is coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      side_refresh_request_q     <= 1'b0;
      side_total_field_height_q  <= '0;
      side_active_field_height_q <= '0;
      side_interlace_flag_q      <= 1'b0;
    end else begin
      if (side_refresh_request_q && done_q[1]) begin
        side_total_field_height_q  <= res_q[1].tot_half[HALF_W-1:1];
        side_active_field_height_q <= res_q[1].act;
        side_interlace_flag_q      <= res_q[1].mid ^ mprev_q[1];
      end
      // A new request in the capture cycle is kept pending
      if (wr_en && paddr == A_REQ && pwdata[REQ_BIT]) begin
        side_refresh_request_q <= 1'b1;
      end else if (done_q[1]) begin
        side_refresh_request_q <= 1'b0;
      end
    end
  end

  assign evt[EVT_LOCK_BIT] = lock_q[0] & ~lock_prev_q;
  assign evt[EVT_LOST_BIT] = ~lock_q[0] & lock_prev_q;
  assign evt[EVT_SIDE_BIT] = side_refresh_request_q & done_q[1];

  // Sticky status; an event in the clear cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      if (wr_en && paddr == A_IRQ_CLR) begin
        irq_st_q <= (irq_st_q & ~pwdata[EVT_W-1:0]) | evt;
      end else begin
        irq_st_q <= irq_st_q | evt;
      end
      irq_q <= |(irq_st_q & irq_en_q);
    end
  end

  // Write takes effect on the completing access cycle
  assign wr_en = psel & penable & pready_q & pwrite & pstrb[0];

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_port_q                   <= PORT_RST;
      side_port_choice_q            <= PORT_RST;
      alt_vertical_extract_enable_q <= ALT_RST;
      irq_en_q                      <= IRQ_EN_RST;
    end else if (wr_en) begin
      if (paddr == A_CTRL) begin
        main_port_q        <= pwdata[MAIN_PORT_LSB +: PSEL_W];
        side_port_choice_q <= pwdata[SIDE_PORT_LSB +: PSEL_W];
      end else if (paddr == A_ALT_EN) begin
        alt_vertical_extract_enable_q <= pwdata[ALT_EN_BIT];
      end else if (paddr == A_IRQ_EN) begin
        irq_en_q <= pwdata[EVT_W-1:0];
      end
    end
  end

  // Read decode; write-only registers read as zero
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    if (paddr == A_INTERLACE) begin
      rd_data[INTERLACE_BIT] = ilace_q[0];
    end else if (paddr == A_F1_PULSE) begin
      rd_data[HALF_W-1:0] = field1_sync_pulse_width_q;
    end else if (paddr == A_F1_PORCH) begin
      rd_data[HALF_W-1:0] = field1_sync_back_porch_q;
    end else if (paddr == A_ALT_EN) begin
      rd_data[ALT_EN_BIT] = alt_vertical_extract_enable_q;
    end else if (paddr == A_CTRL) begin
      rd_data[MAIN_PORT_LSB +: PSEL_W] = main_port_q;
      rd_data[SIDE_PORT_LSB +: PSEL_W] = side_port_choice_q;
    end else if (paddr == A_REQ || paddr == A_IRQ_CLR) begin
      rd_data = '0;
    end else if (paddr == A_STATUS) begin
      rd_data[ST_FILT_BIT] = filt_lock_q;
      rd_data[ST_RAW_BIT]  = lock_q[0];
      rd_data[ST_SIDE_BIT] = lock_q[1];
      rd_data[ST_PEND_BIT] = side_refresh_request_q;
    end else if (paddr == A_IRQ_STAT) begin
      rd_data[EVT_W-1:0] = irq_st_q;
    end else if (paddr == A_IRQ_EN) begin
      rd_data[EVT_W-1:0] = irq_en_q;
    end else if (paddr == A_SIDE_ACT) begin
      rd_data[LINE_W-1:0] = side_active_field_height_q;
    end else if (paddr == A_SIDE_TOT) begin
      rd_data[LINE_W-1:0] = side_total_field_height_q;
    end else if (paddr == A_SIDE_IL) begin
      rd_data[SIDE_IL_BIT] = side_interlace_flag_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One wait state keeps ready and data straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~rd_hit;
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= rd_data;
      end
    end
  end

endmodule

/* bench/vsm_sync_source.sv */
// Behavioural video source driving one decoded sync stream
`timescale 1ns/1ns
module vsm_sync_source #(
  parameter int HL = 16  // Pixel clocks in half a line
) (
  input  wire logic       pclk,  // Pixel clock
  input  wire logic       run,   // Source active, quiet lines when low
  input  wire logic       ilace, // Two fields per frame
  input  wire logic [7:0] fh,    // Half lines in one field
  input  wire logic [7:0] pw,    // Sync pulse, half lines
  input  wire logic [7:0] ast,   // First active half line
  input  wire logic [7:0] act,   // Active lines per field
  output vsm_pkg::vsm_sync_type sync // Stream into the port
);
  import vsm_pkg::*;
  int c;
  int fr;
  int t;
  int h;
  int p;
  // Frame cycle counter, restarts while the source is stopped
  always_ff @(posedge pclk) begin
    c <= (!run || c >= fr - 1) ? 0 : c + 1;
  end
  // Edges sit one pixel after each half tick so no count is ambiguous;
  // with an odd field length the second field starts in mid-line
  always_comb begin
    fr = (ilace ? 2 * int'(fh) : int'(fh)) * HL;
    t = (c == 0) ? fr - 1 : c - 1;
    h = t / HL;
    if (ilace && h >= int'(fh)) h = h - int'(fh);
    p = c % (2 * HL);
    sync.hs = run && p < 2;
    sync.vs = run && h < int'(pw);
    sync.de = run && p >= 2 && p < HL && h >= int'(ast)
              && h < int'(ast) + 2 * int'(act);
  end
endmodule

/* bench/vsm_vertical_measure_properties.sv */
// Checker: bus timing and readback shape of the sync measurement block
`timescale 1ns/1ns
module vsm_vm_props #(
  parameter int NUM_PORTS = 2  // Sync ports
) (
  input wire logic                       pclk,    // Clock
  input wire logic                       presetn, // Reset
  input wire logic                       psel,    // Select
  input wire logic                       penable, // Enable
  input wire logic                       pwrite,  // Direction
  input wire logic [vsm_pkg::ADDR_W-1:0] paddr,   // Address
  input wire logic [31:0]                pwdata,  // Write data
  input wire logic [3:0]                 pstrb,   // Strobes
  input wire logic [31:0]                prdata,  // Read data
  input wire logic                       pready,  // Ready
  input wire logic                       pslverr, // Error
  input wire vsm_pkg::vsm_sync_type [NUM_PORTS-1:0] port_sync, // Sync
  input wire logic                       irq      // Interrupt
);
  import vsm_pkg::*;
  logic rd;
  logic alt_q;
  function automatic logic [ADDR_W-1:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  assign rd = pready && !pwrite;
  // Shadow follows only completed strobed writes, as the slave must
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_q <= ALT_RST;
    end else if (pready && pwrite && pstrb[0]
                 && paddr == ba(IDX_ALT_EN)) begin
      alt_q <= pwdata[ALT_EN_BIT];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_WAIT: assert property (psel && penable && !$past(penable)
    |-> !pready ##1 pready) else $error("ready not after one wait");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_PAIRED: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside ready");
  AST_PULSE_W: assert property (rd && paddr == ba(IDX_F1_PULSE)
    |-> prdata[31:HALF_W] == '0) else $error("pulse readback too wide");
  AST_PORCH_W: assert property (rd && paddr == ba(IDX_F1_PORCH)
    |-> prdata[31:HALF_W] == '0) else $error("porch readback too wide");
  AST_SIDE_H: assert property (rd && (paddr == ba(IDX_SIDE_ACT)
    || paddr == ba(IDX_SIDE_TOT)) |-> prdata[31:LINE_W] == '0)
    else $error("height readback too wide");
  AST_IL_BIT: assert property (rd && paddr == ba(IDX_INTERLACE)
    |-> (prdata & ~(32'h1 << INTERLACE_BIT)) == '0)
    else $error("interlace readback stray bits");
  AST_SIDE_IL: assert property (rd && paddr == ba(IDX_SIDE_IL)
    |-> prdata[31:1] == '0) else $error("side interlace stray bits");
  AST_ALT_RW: assert property (rd && paddr == ba(IDX_ALT_EN)
    |-> prdata == (32'(alt_q) << ALT_EN_BIT))
    else $error("enable bit readback wrong");
  AST_LOCK_ORDER: assert property (rd && paddr == ba(IDX_STATUS)
    && prdata[ST_FILT_BIT] |-> prdata[ST_RAW_BIT])
    else $error("filter lock without raw lock");
  AST_HOLD: assert property ($changed(prdata) |-> rd)
    else $error("read data moved outside a read");
  cover property (rd && paddr == ba(IDX_STATUS) && prdata[1:0] == 2'h3);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule
bind vsm_vertical_measure vsm_vm_props #(.NUM_PORTS(NUM_PORTS)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .port_sync, .irq);

/* bench/testbench.sv */
// Bench: register bus, lock filter, port choice, background, interrupt
`timescale 1ns/1ns
module testbench;
  import vsm_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite;
  logic               pready, pslverr, irq;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         pstrb;
  vsm_sync_type [1:0] sync;
  logic [1:0]         run, ilace;
  logic [7:0]         fh [2], pw [2], ast [2], act [2];
  logic [7:0]         ro_idx [6] = '{IDX_INTERLACE, IDX_F1_PULSE,
    IDX_F1_PORCH, IDX_SIDE_ACT, IDX_SIDE_TOT, IDX_SIDE_IL};
  logic [31:0]        m_all = 32'hFFFFFFFF;
  int                 n_fail, n_tests, cyc;

  // Port 0 and port 1 each carry their own source
  for (genvar i = 0; i < 2; i++) begin : g_src
    vsm_sync_source u_src (.pclk(pclk), .run(run[i]), .ilace(ilace[i]),
      .fh(fh[i]), .pw(pw[i]), .ast(ast[i]), .act(act[i]), .sync(sync[i]));
  end
  vsm_vertical_measure DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_sync(sync), .irq(irq));

  always #25 pclk = ~pclk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A hung wait must still reach the verdict
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      $display("[ERR] run length exp done got hang");
      n_fail++;
      end_sim();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] x,
                     input string nm);
    n_tests++;
    if (g !== x) begin
      $display("[ERR] %s exp %h got %h", nm, x, g);
      n_fail++;
    end
  endtask

  // One bus transfer; request held until ready is sampled high
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) cmp(32'h0, 32'h1, "pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    bus(1'b1, i, d, r, e);
  endtask

  // Reads until the masked value shows, then judges the last read
  task automatic poll(input logic [7:0] i, input logic [31:0] m,
                      input logic [31:0] x, input int lim);
    logic [31:0] r;
    logic        e;
    for (int k = 0; k < lim; k++) begin
      bus(1'b0, i, 32'h0, r, e);
      if ((r & m) === x) break;
    end
    cmp(r & m, x, $sformatf("reg %h", i));
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    foreach (ro_idx[k]) poll(ro_idx[k], m_all, 32'h0, 1);
    poll(IDX_ALT_EN, m_all, 32'h0, 1);
    wr(IDX_ALT_EN, 32'h4);
    poll(IDX_ALT_EN, m_all, 32'h4, 1);
    pstrb <= 4'h0;
    wr(IDX_ALT_EN, 32'h0);
    pstrb <= 4'hF;
    poll(IDX_ALT_EN, m_all, 32'h4, 1);
    wr(IDX_ALT_EN, 32'h0);
    wr(IDX_F1_PULSE, 32'h3FFF);
    poll(IDX_F1_PULSE, m_all, 32'h0, 1);
    bus(1'b0, 8'h77, 32'h0, r, e);
    cmp(32'(e), 32'h1, "unmapped error");
    cmp(r, 32'h0, "unmapped data");
  endtask

  task automatic t_main();
    run[0] <= 1'b1;
    wr(IDX_IRQ_EN, 32'h7);
    poll(IDX_STATUS, 32'h3, 32'h3, 4000);
    poll(IDX_F1_PULSE, m_all, 32'h6, 1500);
    poll(IDX_F1_PORCH, m_all, 32'hF, 1);
    poll(IDX_INTERLACE, m_all, 32'h20, 400);
    poll(IDX_IRQ_STAT, 32'h1, 32'h1, 1);
    cmp(32'(irq), 32'h1, "irq raised");
    wr(IDX_IRQ_CLR, 32'h7);
    poll(IDX_IRQ_STAT, m_all, 32'h0, 1);
    cmp(32'(irq), 32'h0, "irq cleared");
  endtask

  // New field length: two mismatching fields drop the lock
  task automatic t_unlock();
    wr(IDX_IRQ_EN, 32'h0);
    fh[0] <= 8'h53;
    poll(IDX_IRQ_STAT, 32'h2, 32'h2, 3000);
    poll(IDX_STATUS, 32'h3, 32'h0, 1);
    cmp(32'(irq), 32'h0, "irq masked");
    wr(IDX_IRQ_EN, 32'h2);
    poll(IDX_IRQ_STAT, 32'h2, 32'h2, 1);
    cmp(32'(irq), 32'h1, "irq enabled");
    wr(IDX_IRQ_CLR, 32'h7);
    poll(IDX_STATUS, 32'h3, 32'h3, 4000);
    poll(IDX_F1_PULSE, m_all, 32'h6, 1500);
  endtask

  task automatic t_port();
    wr(IDX_CTRL, 32'h2);
    poll(IDX_CTRL, m_all, 32'h2, 1);
    poll(IDX_STATUS, 32'h3, 32'h0, 2);
    wr(IDX_CTRL, 32'h1);
    poll(IDX_STATUS, 32'h3, 32'h3, 2000);
    poll(IDX_INTERLACE, m_all, 32'h0, 400);
    poll(IDX_F1_PULSE, m_all, 32'h6, 1);
    wr(IDX_ALT_EN, 32'h4);
    wr(IDX_CTRL, 32'h0);
    poll(IDX_STATUS, 32'h3, 32'h3, 4000);
    poll(IDX_INTERLACE, m_all, 32'h20, 400);
    wr(IDX_ALT_EN, 32'h0);
  endtask

  // Two requests, so the capture never falls on a half-settled field
  task automatic side_req();
    for (int k = 0; k < 2; k++) begin
      wr(IDX_REQ, 32'h1);
      poll(IDX_STATUS, 32'h8, 32'h8, 1);
      poll(IDX_STATUS, 32'hC, 32'h4, 3000);
    end
  endtask

  task automatic t_side();
    wr(IDX_CTRL, 32'h10);
    side_req();
    poll(IDX_SIDE_TOT, m_all, 32'h19, 1);
    poll(IDX_SIDE_ACT, m_all, 32'h12, 1);
    poll(IDX_SIDE_IL, m_all, 32'h0, 1);
    poll(IDX_IRQ_STAT, 32'h4, 32'h4, 1);
    wr(IDX_CTRL, 32'h0);
    poll(IDX_SIDE_TOT, m_all, 32'h19, 1);
    side_req();
    poll(IDX_SIDE_TOT, m_all, 32'h29, 1);
    poll(IDX_SIDE_ACT, m_all, 32'h19, 1);
    poll(IDX_SIDE_IL, m_all, 32'h1, 1);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    run = 2'b10;
    ilace = 2'b01;
    fh = '{8'h51, 8'h32};
    pw = '{8'h6, 8'h4};
    ast = '{8'h14, 8'hA};
    act = '{8'h19, 8'h12};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_main();
    t_unlock();
    t_port();
    t_side();
    end_sim();
  end
endmodule
